// File: hdl/card_config_regs.vh
// Offsets, field positions, reset values and timing counts of the card setup
`ifndef CARD_CONFIG_REGS_VH
`define CARD_CONFIG_REGS_VH

// ---------------------------------------------------------------
// Register offsets in attribute space
// ---------------------------------------------------------------
`define CFG_BASE_OFFSET 11'h200
`define OPTION_SETUP_OFFSET 11'h200
`define CARD_STATE_OFFSET 11'h202
`define SIGNAL_SUBSTITUTE_OFFSET 11'h204
`define SLOT_DRIVE_OFFSET 11'h206

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SOFT_RESET_BIT_POS 7
`define LEVEL_IRQ_SELECT_POS 6
`define CONFIG_INDEX_MSB 5
`define CHANGED_POS 7
`define STATUS_CHANGE_ENABLE_POS 6
`define BYTE_IO_REQUEST_POS 5
`define POWER_SAVE_REQUEST_POS 2
`define IRQ_STATE_POS 1
`define READY_CHANGED_POS 5
`define WP_CHANGED_POS 4
`define READY_STATE_POS 1
`define WP_MASK_POS 0
`define DRIVE_NUMBER_POS 4

// ---------------------------------------------------------------
// Reset values and mode codes
// ---------------------------------------------------------------
`define OPTION_SETUP_RESET 8'h00
`define CARD_STATE_RESET 8'h00
`define SLOT_DRIVE_RESET 8'h00
`define MODE_MEMORY 6'h00
`define MODE_CONTIGUOUS_IO 6'h01
`define MODE_PRIMARY_IO 6'h02
`define MODE_SECONDARY_IO 6'h03

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLOCK_PERIOD_NS 10
`define POWER_SWITCH_NS 1000
`define POWER_SWITCH_CYCLES \
   ((`POWER_SWITCH_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// File: hdl/card_power_tracker.v
// Power state of the card with busy time on every state change except reset or clear
`timescale 1ns/1ps
`include "card_config_regs.vh"

module card_power_tracker #(
   parameter SWITCH_CYCLES = `POWER_SWITCH_CYCLES
) (
   input wire i_clock,
   input wire i_rst,
   input wire i_clear,
   input wire i_request_write,
   input wire i_request_value,
   input wire i_idle,
   input wire i_command_arrived,
   output reg o_power_saving,
   output wire o_ready
);

   reg [15:0] busy_count;
   reg next_saving;
   reg change;

   always @* begin
      next_saving = o_power_saving;
      if (i_request_write) begin
         next_saving = i_request_value;
      end else if (i_command_arrived) begin
         next_saving = 1'b0;
      end else if (i_idle) begin
         next_saving = 1'b1;
      end
      change = next_saving != o_power_saving;
   end

   // ---------------------------------------------------------------
   // State and busy countdown
   // ---------------------------------------------------------------
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_power_saving <= 1'b0;
         busy_count <= 16'h0000;
      end else if (i_clear) begin
         o_power_saving <= 1'b0;
         busy_count <= 16'h0000;
      end else begin
         o_power_saving <= next_saving; // [RULE15] [RULE16]
         if (change) begin
            busy_count <= SWITCH_CYCLES[15:0]; // [RULE15]
         end else if (busy_count != 16'h0000) begin
            busy_count <= busy_count - 16'h0001;
         end
      end
   end

   assign o_ready = busy_count == 16'h0000;

endmodule // card_power_tracker

// File: hdl/card_config_register_decode.v
// Attribute-space decode and card configuration registers
`timescale 1ns/1ps
`include "card_config_regs.vh"

// Summary of operation
// RULE1 - Config registers sit at attribute 200h, apart from common memory.
// RULE2 - Host writes attribute space only at config register locations.
// RULE3 - Hit on low enable, attribute select, A10=0, A9=1, A8..A3=0, A0=0.
// RULE4 - Attribute select high decodes common memory low, high or word lanes.
// RULE5 - Structure read on A10=A9=0, A0=0; both enables high is standby.
// RULE6 - Structure writes and odd-byte structure accesses flag invalid.
// RULE7 - Soft-reset bit holds card in reset; clearing leaves it unconfigured.
// RULE8 - Soft-reset bit clears on power-up and hardware reset.
// RULE9 - Interrupt-mode bit selects level when 1, pulse when 0; resets 0.
// RULE10 - Six-bit index picks memory, contiguous, primary or secondary I/O.
// RULE11 - Task-file addresses decoded per selected mode.
// RULE12 - Changed is ready-changed or wp-changed; status pin low if enabled.
// RULE13 - Status-change enable is read/write; when 0 in I/O, status pin high.
// RULE14 - Eight-bit I/O request is stored for readback and otherwise ignored.
// RULE15 - Power-down bit selects power saving; any change makes ready busy.
// RULE16 - Card sleeps when idle and wakes on a command by itself.
// RULE17 - Interrupt bit mirrors internal request; 0 when disable bit set.
// RULE18 - Host finds register locations through the information structure.
// RULE19 - Ready-changed flag sets whenever internal ready toggles.
// RULE20 - Host uses 8-bit even accesses in attribute space, low byte only.
// RULE21 - Status changed, interrupt bits ignore writes; D4, D3, D0 read 0.
module card_config_register_decode #(
   parameter SWITCH_CYCLES = `POWER_SWITCH_CYCLES
) (
   input wire i_clock,
   input wire i_rst,
   input wire i_low_byte_enable_n,
   input wire i_high_byte_enable_n,
   input wire i_attr_select_n,
   input wire i_read_strobe_n,
   input wire i_write_strobe_n,
   input wire i_io_read_n,
   input wire i_io_write_n,
   input wire [10:0] i_addr,
   input wire [7:0] i_data,
   input wire i_irq_request,
   input wire i_irq_disable_bit,
   input wire i_idle,
   input wire i_command_arrived,
   output reg [7:0] o_data,
   output reg o_data_oe,
   output wire o_status_changed_out_n,
   output wire o_soft_reset_active,
   output wire o_level_irq_select,
   output wire [5:0] o_config_index,
   output wire o_io_mode,
   output wire o_power_saving,
   output wire o_ready,
   output wire o_standby,
   output wire o_common_low_lane,
   output wire o_common_high_lane,
   output wire o_common_word,
   output wire o_info_read,
   output wire o_invalid_access,
   output wire o_taskfile_hit
);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   localparam PIN_W = 7 + 11 + 8;
   wire [PIN_W-1:0] pins_raw;
   reg [PIN_W-1:0] pins_meta;
   reg [PIN_W-1:0] pins_sync;
   reg write_strobe_prev;

   assign pins_raw = {i_low_byte_enable_n, i_high_byte_enable_n,
      i_attr_select_n, i_read_strobe_n, i_write_strobe_n, i_io_read_n,
      i_io_write_n, i_addr, i_data};

   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         pins_meta <= {PIN_W{1'b1}};
         pins_sync <= {PIN_W{1'b1}};
         write_strobe_prev <= 1'b1;
      end else begin
         pins_meta <= pins_raw;
         pins_sync <= pins_meta;
         write_strobe_prev <= pins_sync[PIN_W-5];
      end
   end

   wire ce1_n = pins_sync[PIN_W-1];
   wire ce2_n = pins_sync[PIN_W-2];
   wire reg_n = pins_sync[PIN_W-3];
   wire oe_n = pins_sync[PIN_W-4];
   wire we_n = pins_sync[PIN_W-5];
   wire iord_n = pins_sync[PIN_W-6];
   wire iowr_n = pins_sync[PIN_W-7];
   wire [10:0] addr = pins_sync[18:8];
   wire [7:0] wdata = pins_sync[7:0];
   // One write per falling edge of the synchronised strobe
   wire write_edge = write_strobe_prev & ~we_n;

   // ---------------------------------------------------------------
   // Space decode
   // ---------------------------------------------------------------
   wire mem_read = ~oe_n & we_n;
   wire mem_write = oe_n & ~we_n;
   wire attr_cycle = ~reg_n & (mem_read | mem_write);
   wire cfg_hit = ~ce1_n & ~reg_n & ~addr[10] & addr[9]
      & (addr[8:3] == 6'h00) & ~addr[0]; // [RULE1] [RULE3]
   wire [1:0] cfg_sel = addr[2:1]; // [RULE3]
   wire cis_space = ~addr[10] & ~addr[9];
   wire odd_attr = (~ce1_n & ce2_n & addr[0]) | (ce1_n & ~ce2_n);

   assign o_standby = ce1_n & ce2_n; // [RULE5]
   assign o_common_low_lane = reg_n & ~ce1_n & ce2_n
      & (mem_read | mem_write); // [RULE4]
   assign o_common_high_lane = reg_n & ce1_n & ~ce2_n
      & (mem_read | mem_write); // [RULE4]
   assign o_common_word = reg_n & ~ce1_n & ~ce2_n & ~addr[0]
      & (mem_read | mem_write); // [RULE4]
   assign o_info_read = ~reg_n & ~ce1_n & mem_read & cis_space
      & ~addr[0]; // [RULE5]
   assign o_invalid_access = attr_cycle & ~o_standby
      & ((~ce1_n & cis_space & mem_write) | odd_attr); // [RULE6]

   // Writes act once, on the first synchronised low of the strobe
   wire cfg_write = cfg_hit & mem_write & write_edge;

   // ---------------------------------------------------------------
   // Option setup register
   // ---------------------------------------------------------------
   reg [7:0] option_setup_reg;
   wire soft_reset = option_setup_reg[`SOFT_RESET_BIT_POS];
   wire wr_option = cfg_write & (cfg_sel == 2'd0);

   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         option_setup_reg <= `OPTION_SETUP_RESET; // [RULE8] [RULE9] [RULE10]
      end else if (wr_option) begin
         if (wdata[`SOFT_RESET_BIT_POS]) begin
            option_setup_reg <= 8'h80; // [RULE7]
         end else begin
            option_setup_reg <= wdata;
         end
      end
   end

   assign o_soft_reset_active = soft_reset; // [RULE7]
   assign o_level_irq_select =
      option_setup_reg[`LEVEL_IRQ_SELECT_POS]; // [RULE9]
   assign o_config_index = option_setup_reg[`CONFIG_INDEX_MSB:0]; // [RULE10]
   assign o_io_mode = o_config_index != `MODE_MEMORY;

   // ---------------------------------------------------------------
   // Task-file decode per mode
   // ---------------------------------------------------------------
   reg tf_range;
   always @* begin
      case (o_config_index)
         `MODE_MEMORY: begin
            tf_range = addr[10] | (addr[9:4] == 6'h00);
         end
         `MODE_CONTIGUOUS_IO: begin
            tf_range = 1'b1;
         end
         `MODE_PRIMARY_IO: begin
            tf_range = (addr[9:3] == 7'h3E) | (addr[9:1] == 9'h1FB);
         end
         `MODE_SECONDARY_IO: begin
            tf_range = (addr[9:3] == 7'h2E) | (addr[9:1] == 9'h1BB);
         end
         default: begin
            tf_range = 1'b0;
         end
      endcase
   end

   assign o_taskfile_hit = ~soft_reset & ~o_standby & tf_range
      & (o_io_mode ? (~reg_n & (~iord_n | ~iowr_n))
         : (reg_n & (mem_read | mem_write))); // [RULE11]

   // ---------------------------------------------------------------
   // Card state register and power
   // ---------------------------------------------------------------
   reg status_change_enable;
   reg byte_io_request;
   reg power_save_request;
   wire wr_state = cfg_write & (cfg_sel == 2'd1);

   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         status_change_enable <= 1'b0;
         byte_io_request <= 1'b0;
         power_save_request <= 1'b0;
      end else if (soft_reset) begin
         status_change_enable <= 1'b0;
         byte_io_request <= 1'b0;
         power_save_request <= 1'b0;
      end else if (wr_state) begin
         status_change_enable <= wdata[`STATUS_CHANGE_ENABLE_POS]; // [RULE13]
         byte_io_request <= wdata[`BYTE_IO_REQUEST_POS]; // [RULE14]
         power_save_request <= wdata[`POWER_SAVE_REQUEST_POS]; // [RULE15]
      end
   end

   card_power_tracker #(
      .SWITCH_CYCLES(SWITCH_CYCLES)
   ) power_tracker (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_clear(soft_reset),
      .i_request_write(wr_state),
      .i_request_value(wdata[`POWER_SAVE_REQUEST_POS]),
      .i_idle(i_idle),
      .i_command_arrived(i_command_arrived),
      .o_power_saving(o_power_saving),
      .o_ready(o_ready)
   );

   // ---------------------------------------------------------------
   // Signal substitute and slot drive registers
   // ---------------------------------------------------------------
   reg ready_changed_flag;
   reg wp_changed_flag;
   reg ready_prev;
   reg drive_number;
   wire wr_subst = cfg_write & (cfg_sel == 2'd2);
   wire wr_slot = cfg_write & (cfg_sel == 2'd3);
   wire ready_toggle = ready_prev ^ o_ready;

   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ready_changed_flag <= 1'b0;
         wp_changed_flag <= 1'b0;
         ready_prev <= 1'b1;
         drive_number <= 1'b0;
      end else begin
         ready_prev <= o_ready;
         if (soft_reset) begin
            ready_changed_flag <= 1'b0;
            wp_changed_flag <= 1'b0;
            drive_number <= 1'b0;
         end else begin
            // A hardware set wins over a host write in the same cycle
            if (ready_toggle) begin
               ready_changed_flag <= 1'b1; // [RULE19]
            end else if (wr_subst & wdata[`READY_STATE_POS]) begin
               ready_changed_flag <= wdata[`READY_CHANGED_POS];
            end
            if (wr_subst & wdata[`WP_MASK_POS]) begin
               wp_changed_flag <= wdata[`WP_CHANGED_POS];
            end
            if (wr_slot) begin
               drive_number <= wdata[`DRIVE_NUMBER_POS];
            end
         end
      end
   end

   wire changed = ready_changed_flag | wp_changed_flag; // [RULE12]
   wire irq_state = i_irq_request & ~i_irq_disable_bit; // [RULE17]
   // Status pin follows changed only in I/O configuration
   assign o_status_changed_out_n = ~(o_io_mode & changed
      & status_change_enable); // [RULE12] [RULE13]

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   reg [7:0] read_value;
   always @* begin
      case (cfg_sel)
         2'd0: begin
            read_value = option_setup_reg;
         end
         2'd1: begin
            read_value = {changed, status_change_enable, byte_io_request,
               2'b00, power_save_request, irq_state, 1'b0}; // [RULE21]
         end
         2'd2: begin
            read_value = {2'b00, ready_changed_flag, wp_changed_flag,
               2'b11, o_ready, 1'b0};
         end
         2'd3: begin
            read_value = {3'b000, drive_number, 4'h0};
         end
         default: begin
            read_value = 8'h00;
         end
      endcase
   end

   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_data <= 8'h00;
         o_data_oe <= 1'b0;
      end else begin
         // Read data is registered while the decode holds
         o_data_oe <= cfg_hit & mem_read;
         if (cfg_hit & mem_read) begin
            o_data <= read_value;
         end
      end
   end

endmodule // card_config_register_decode

// File: tb/card_config_register_decode_props.sv
// Concurrent checks on the card setup block ports
`timescale 1ns/1ps
module card_config_register_decode_props #(
   parameter int SWITCH_CYCLES = 100
) (
   input wire i_clock,
   input wire i_rst,
   input wire i_low_byte_enable_n,
   input wire i_high_byte_enable_n,
   input wire i_attr_select_n,
   input wire i_read_strobe_n,
   input wire i_write_strobe_n,
   input wire [10:0] i_addr,
   input wire o_data_oe,
   input wire o_status_changed_out_n,
   input wire o_soft_reset_active,
   input wire o_level_irq_select,
   input wire [5:0] o_config_index,
   input wire o_io_mode,
   input wire o_power_saving,
   input wire o_ready,
   input wire o_standby,
   input wire o_common_low_lane,
   input wire o_info_read,
   input wire o_invalid_access
);
   localparam int BUSY_LIMIT = SWITCH_CYCLES + 4;
   wire cis_sel = !i_attr_select_n && !i_low_byte_enable_n
      && i_addr[10:9] == 2'b00 && !i_addr[0];
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // ------
   // Decode and registers
   // ------
   a_standby_both_high: assert property (
      (i_low_byte_enable_n && i_high_byte_enable_n)[*3] |-> o_standby)
      else $error("standby not decoded");
   a_low_lane_only: assert property (
      (!i_low_byte_enable_n && i_high_byte_enable_n && i_attr_select_n
      && !i_read_strobe_n && i_write_strobe_n)[*3]
      |-> o_common_low_lane) else $error("low lane not decoded");
   a_info_read_decode: assert property (
      (cis_sel && i_high_byte_enable_n && !i_read_strobe_n
      && i_write_strobe_n)[*3] |-> o_info_read)
      else $error("structure read not decoded");
   a_cis_write_invalid: assert property (
      (cis_sel && !i_write_strobe_n && i_read_strobe_n)[*3]
      |-> o_invalid_access) else $error("structure write not flagged");
   a_odd_byte_invalid: assert property (
      (!i_attr_select_n && i_low_byte_enable_n && !i_high_byte_enable_n
      && !i_read_strobe_n)[*3] |-> o_invalid_access)
      else $error("odd byte access not flagged");
   a_read_answer_cause: assert property (
      o_data_oe |-> !$past(i_read_strobe_n, 3) && !$past(i_attr_select_n, 3))
      else $error("read data without a register read");
   a_io_mode_index: assert property (
      o_io_mode == (o_config_index != 6'h00))
      else $error("mode does not follow index");
   a_memory_status_high: assert property (
      !o_io_mode |-> o_status_changed_out_n)
      else $error("status pin low in memory mode");
   a_soft_reset_holds: assert property (
      o_soft_reset_active[*2] |-> o_config_index == 6'h00
      && !o_level_irq_select && !o_power_saving)
      else $error("state kept during soft reset");
   a_busy_bounded: assert property (
      $fell(o_ready) |-> ##[1:BUSY_LIMIT] o_ready)
      else $error("busy lasts too long");
endmodule // card_config_register_decode_props

bind card_config_register_decode card_config_register_decode_props #(
   .SWITCH_CYCLES(SWITCH_CYCLES)) card_config_register_decode_props_inst (
   .i_clock, .i_rst, .i_low_byte_enable_n, .i_high_byte_enable_n,
   .i_attr_select_n, .i_read_strobe_n, .i_write_strobe_n, .i_addr,
   .o_data_oe, .o_status_changed_out_n, .o_soft_reset_active,
   .o_level_irq_select, .o_config_index, .o_io_mode, .o_power_saving,
   .o_ready, .o_standby, .o_common_low_lane, .o_info_read,
   .o_invalid_access);

// File: tb/host_socket_model.sv
// Host socket model that drives the card bus pins
`timescale 1ns/1ps
module host_socket_model (
   input wire i_clock,
   output wire o_low_byte_enable_n,
   output wire o_high_byte_enable_n,
   output wire o_attr_select_n,
   output wire o_read_strobe_n,
   output wire o_write_strobe_n,
   output wire o_io_read_n,
   output wire [10:0] o_addr,
   output wire [7:0] o_data
);
   logic [5:0] pins = 6'h3f;
   logic [10:0] addr = 11'h000;
   logic [7:0] data = 8'h00;
   assign {o_low_byte_enable_n, o_high_byte_enable_n, o_attr_select_n,
      o_read_strobe_n, o_write_strobe_n, o_io_read_n} = pins;
   assign o_addr = addr;
   assign o_data = data;
   // ------
   // Bus cycles
   // ------
   // Starts a cycle on the lanes and strobes given in p just after an edge
   task automatic drive(input logic [5:0] p, input logic [10:0] a,
         input logic [7:0] d);
      @(posedge i_clock);
      pins <= p;
      addr <= a;
      data <= d;
   endtask
   // Ends a cycle with enables and strobes high for three edges
   task automatic release_bus;
      @(posedge i_clock);
      pins <= 6'h3f;
      data <= ~data;
      repeat (3) @(posedge i_clock);
   endtask
endmodule // host_socket_model

// File: tb/card_config_register_decode_tb.sv
// Self-checking bench for the card setup register block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   bad_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module card_config_register_decode_tb;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic irq_req = 1'b0;
   logic irq_dis = 1'b0;
   logic idle = 1'b0;
   logic cmd = 1'b0;
   logic iow_n = 1'b1;
   logic [3:0] dec;
   int bad_count = 0;
   int n_checks = 0;
   wire le_n, he_n, at_n, rd_n, wr_n, io_n;
   wire [10:0] addr;
   wire [7:0] wdata, rdata;
   wire [5:0] idx;
   wire oe, sts_n, srst, lvl, iom, psave, rdy, stby, lo, hi, word, info;
   wire inval, tf;
   logic [5:0] dc_pins [5] = '{6'b001011, 6'b101011, 6'b010011,
      6'b010101, 6'b100011};
   logic [3:0] dc_exp [5] = '{4'b1000, 4'b0100, 4'b0010, 4'b0001, 4'b0001};
   logic [1:0] tf_mode [8] = '{2'd0, 2'd0, 2'd1, 2'd2, 2'd2, 2'd3, 2'd3,
      2'd2};
   logic [10:0] tf_addr [8] = '{11'h405, 11'h010, 11'h3a5, 11'h1f0,
      11'h3f7, 11'h376, 11'h1f0, 11'h170};
   logic tf_hit [8] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
   logic [10:0] bad_addr [3] = '{11'h208, 11'h201, 11'h600};
   always #5 i_clock = ~i_clock;
   card_config_register_decode #(.SWITCH_CYCLES(12))
         card_config_register_decode_inst (
      .i_clock(i_clock), .i_rst(i_rst), .i_low_byte_enable_n(le_n),
      .i_high_byte_enable_n(he_n), .i_attr_select_n(at_n),
      .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n), .i_io_read_n(io_n),
      .i_io_write_n(iow_n), .i_addr(addr), .i_data(wdata),
      .i_irq_request(irq_req), .i_irq_disable_bit(irq_dis), .i_idle(idle),
      .i_command_arrived(cmd), .o_data(rdata), .o_data_oe(oe),
      .o_status_changed_out_n(sts_n), .o_soft_reset_active(srst),
      .o_level_irq_select(lvl), .o_config_index(idx), .o_io_mode(iom),
      .o_power_saving(psave), .o_ready(rdy), .o_standby(stby),
      .o_common_low_lane(lo), .o_common_high_lane(hi), .o_common_word(word),
      .o_info_read(info), .o_invalid_access(inval), .o_taskfile_hit(tf));
   host_socket_model host_socket_model_inst (
      .i_clock(i_clock), .o_low_byte_enable_n(le_n),
      .o_high_byte_enable_n(he_n), .o_attr_select_n(at_n),
      .o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n), .o_io_read_n(io_n),
      .o_addr(addr), .o_data(wdata));
   // ------
   // Tasks
   // ------
   task automatic report_and_stop;
      $display("Checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic access(input logic [5:0] p, input logic [10:0] a,
         input logic [7:0] d);
      host_socket_model_inst.drive(p, a, d);
      repeat (4) @(posedge i_clock);
      #1;
   endtask
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      access(6'b010101, a, d);
      host_socket_model_inst.release_bus();
   endtask
   task automatic rchk(input logic [10:0] a, input logic [7:0] e);
      access(6'b010011, a, 8'h00);
      `CHK("read enable", 1'b1, oe)
      `CHK("read data", e, rdata)
      host_socket_model_inst.release_bus();
   endtask
   task automatic wait_for(input logic sel, input logic want);
      for (int i = 0; i < 40 && (sel ? psave : rdy) !== want; i++) begin
         @(posedge i_clock);
         #1;
      end
      `CHK("wait", want, sel ? psave : rdy)
      if (bad_count > 0) begin
         report_and_stop();
      end
   endtask
   // ------
   // Tests
   // ------
   initial begin
      repeat (2) @(posedge i_clock);
      i_rst <= 1'b0;
      repeat (2) @(posedge i_clock);
      rchk(11'h200, 8'h00);
      rchk(11'h202, 8'h00);
      rchk(11'h206, 8'h00);
      for (int k = 0; k < 5; k++) begin
         access(dc_pins[k], 11'h010, 8'h00);
         dec = {word, hi & ~lo, info, inval};
         `CHK("decode", dc_exp[k], dec)
         host_socket_model_inst.release_bus();
         `CHK("standby", 1'b1, stby)
      end
      $display("reset and decode done");
      for (int m = 0; m < 4; m++) begin
         wr(11'h200, 8'h40 | 8'(m));
         rchk(11'h200, 8'h40 | 8'(m));
         `CHK("index", 6'(m), idx)
         `CHK("io mode", m != 0, iom)
         `CHK("level", 1'b1, lvl)
      end
      for (int k = 0; k < 8; k++) begin
         wr(11'h200, {6'h00, tf_mode[k]});
         access(tf_mode[k] == 2'd0 ? 6'b011011 : 6'b010110, tf_addr[k],
            8'h00);
         `CHK("taskfile", tf_hit[k], tf)
         host_socket_model_inst.release_bus();
      end
      iow_n <= 1'b0;
      access(6'b010111, 11'h1f7, 8'h00);
      `CHK("taskfile write", 1'b1, tf)
      host_socket_model_inst.release_bus();
      iow_n <= 1'b1;
      $display("modes done");
      access(6'b010101, 11'h202, 8'h64);
      wait_for(1'b0, 1'b0);
      host_socket_model_inst.release_bus();
      wait_for(1'b0, 1'b1);
      `CHK("power save", 1'b1, psave)
      rchk(11'h202, 8'he4);
      `CHK("status pin", 1'b0, sts_n)
      wr(11'h204, 8'h02);
      rchk(11'h202, 8'h64);
      `CHK("status pin", 1'b1, sts_n)
      wr(11'h202, 8'h9f);
      rchk(11'h202, 8'h04);
      wr(11'h204, 8'h22);
      rchk(11'h202, 8'h84);
      `CHK("status pin", 1'b1, sts_n)
      @(posedge i_clock);
      irq_req <= 1'b1;
      rchk(11'h202, 8'h86);
      irq_dis <= 1'b1;
      rchk(11'h202, 8'h84);
      irq_req <= 1'b0;
      irq_dis <= 1'b0;
      wr(11'h202, 8'h00);
      wait_for(1'b0, 1'b1);
      `CHK("power save", 1'b0, psave)
      @(posedge i_clock);
      idle <= 1'b1;
      wait_for(1'b1, 1'b1);
      @(posedge i_clock);
      idle <= 1'b0;
      cmd <= 1'b1;
      wait_for(1'b1, 1'b0);
      @(posedge i_clock);
      cmd <= 1'b0;
      wait_for(1'b0, 1'b1);
      $display("status and power done");
      wr(11'h200, 8'h81);
      rchk(11'h200, 8'h80);
      `CHK("soft reset", 1'b1, srst)
      rchk(11'h202, 8'h00);
      wr(11'h200, 8'h00);
      rchk(11'h200, 8'h00);
      `CHK("io mode", 1'b0, iom)
      for (int k = 0; k < 3; k++) begin
         wr(bad_addr[k], 8'hff);
      end
      rchk(11'h200, 8'h00);
      $display("soft reset and refusal done");
      report_and_stop();
   end
endmodule // card_config_register_decode_tb
